// >>> design/srnvg_top.sv
// Reset cause and non-maskable vector generator with an APB register slave.
//
// Design decision made here: the APB interface to the registers.

module srnvg_top (
	input  wire logic                     clk_in,
	input  wire logic                     nrst_in,
	input  wire srnvg_pkg::srnvg_apb_req_s apb_in,
	input  wire srnvg_pkg::srnvg_evt_s     evt_in,
	output srnvg_pkg::srnvg_apb_rsp_s      apb_out,
	output logic                          irq_out
);
	logic [srnvg_pkg::NSRC-1:0] ev;
	logic [srnvg_pkg::NSRC-1:0] pend_ff;
	logic [srnvg_pkg::NSRC-1:0] nxt_pend;
	logic [srnvg_pkg::NSRC-1:0] clr_vec;
	logic [srnvg_pkg::NST-1:0]  stat_ff;
	logic [srnvg_pkg::NST-1:0]  nxt_stat;
	logic [srnvg_pkg::NST-1:0]  mask_ff;
	logic [srnvg_pkg::NST-1:0]  nxt_mask;
	logic [srnvg_pkg::NST-1:0]  set_stat;
	logic [31:0]                rdata_ff;
	logic [31:0]                nxt_rdata;
	logic                       err_ff;
	logic                       nxt_err;
	srnvg_pkg::srnvg_idx_t      ridx_ff;
	srnvg_pkg::srnvg_idx_t      nxt_ridx;
	logic                       rvld_ff;
	logic                       nxt_rvld;
	srnvg_pkg::srnvg_sel_e      sel;
	logic                       setup;
	logic                       acc;
	logic                       rclr;
	logic                       usr_v;
	logic                       sys_v;
	logic                       rst_v;
	srnvg_pkg::srnvg_idx_t      usr_i;
	srnvg_pkg::srnvg_idx_t      sys_i;
	srnvg_pkg::srnvg_idx_t      rst_i;

	// Lowest index within the group wins because codes ascend with index.
	function automatic logic [5:0] first_set(
		input logic [srnvg_pkg::NSRC-1:0] p,
		input int                         lo,
		input int                         hi
	);
		logic [5:0] r;
		r = 6'h00;
		for (int i = hi; i >= lo; i--) begin
			if (p[i]) begin
				r = {1'b1, 5'(i)};
			end
		end
		return r;
	endfunction

	assign ev    = evt_in;
	assign setup = apb_in.psel & ~apb_in.penable;
	// The slave never inserts wait states, so every access phase completes.
	assign acc   = apb_in.psel & apb_in.penable;
	assign rclr  = acc & ~apb_in.pwrite & rvld_ff;

	assign {usr_v, usr_i} = first_set(pend_ff, srnvg_pkg::USR_LO, srnvg_pkg::USR_HI);
	assign {sys_v, sys_i} = first_set(pend_ff, srnvg_pkg::SYS_LO, srnvg_pkg::SYS_HI);
	assign {rst_v, rst_i} = first_set(pend_ff, srnvg_pkg::RST_LO, srnvg_pkg::RST_HI);

	always_comb begin
		case (apb_in.paddr)
			srnvg_pkg::USR_ADDR:  sel = srnvg_pkg::SEL_USR;
			srnvg_pkg::SYS_ADDR:  sel = srnvg_pkg::SEL_SYS;
			srnvg_pkg::RST_ADDR:  sel = srnvg_pkg::SEL_RST;
			srnvg_pkg::STAT_ADDR: sel = srnvg_pkg::SEL_STAT;
			srnvg_pkg::MASK_ADDR: sel = srnvg_pkg::SEL_MASK;
			default:              sel = srnvg_pkg::SEL_NONE;
		endcase
	end

	// A new event of a source wins over the read that clears it in the same cycle.
	genvar g;
	generate
		for (g = 0; g < srnvg_pkg::NSRC; g++) begin : g_pend
			assign clr_vec[g]  = rclr & (ridx_ff == 5'(g));
			assign nxt_pend[g] = ev[g] | (pend_ff[g] & ~clr_vec[g]);
		end
	endgenerate

	assign set_stat[srnvg_pkg::ST_SYS] = |ev[srnvg_pkg::SYS_HI:srnvg_pkg::SYS_LO];
	assign set_stat[srnvg_pkg::ST_USR] = |ev[srnvg_pkg::USR_HI:srnvg_pkg::USR_LO];
	assign set_stat[srnvg_pkg::ST_RST] = |ev[srnvg_pkg::RST_HI:srnvg_pkg::RST_LO];

	// Read data is latched in the setup cycle so the access phase sees a stable word.
	always_comb begin
		nxt_rdata = rdata_ff;
		nxt_err   = err_ff;
		nxt_ridx  = ridx_ff;
		nxt_rvld  = 1'b0;
		nxt_stat  = stat_ff | set_stat;
		nxt_mask  = mask_ff;
		if (setup) begin
			nxt_err   = 1'b0;
			nxt_rdata = 32'h00000000;
			nxt_ridx  = 5'h00;
			case (sel)
				srnvg_pkg::SEL_USR: begin
					nxt_rvld = usr_v & ~apb_in.pwrite;
					nxt_ridx = usr_i;
					nxt_rdata[7:0] = usr_v ? srnvg_pkg::CODE[usr_i] : srnvg_pkg::CODE_NONE;
				end
				srnvg_pkg::SEL_SYS: begin
					nxt_rvld = sys_v & ~apb_in.pwrite;
					nxt_ridx = sys_i;
					// Codes 02h, 04h, 12h, 14h, 16h and 18h.
					nxt_rdata[7:0] = sys_v ? srnvg_pkg::CODE[sys_i] : srnvg_pkg::CODE_NONE;
				end
				srnvg_pkg::SEL_RST: begin
					nxt_rvld = rst_v & ~apb_in.pwrite;
					nxt_ridx = rst_i;
					// Codes 02h through 24h, brownout first and lock loss last.
					nxt_rdata[7:0] = rst_v ? srnvg_pkg::CODE[rst_i] : srnvg_pkg::CODE_NONE;
				end
				srnvg_pkg::SEL_STAT: begin
					nxt_rdata[srnvg_pkg::NST-1:0] = stat_ff;
				end
				srnvg_pkg::SEL_MASK: begin
					nxt_rdata[srnvg_pkg::NST-1:0] = mask_ff;
				end
				default: begin
					nxt_err = 1'b1;
				end
			endcase
		end
		if (acc & apb_in.pwrite) begin
			case (sel)
				srnvg_pkg::SEL_STAT: begin
					nxt_stat = (stat_ff & ~apb_in.pwdata[srnvg_pkg::NST-1:0]) | set_stat;
				end
				srnvg_pkg::SEL_MASK: begin
					nxt_mask = apb_in.pwdata[srnvg_pkg::NST-1:0];
				end
				default: begin
					nxt_mask = mask_ff;
				end
			endcase
		end
	end

	// Brownout is pending after reset since this block is itself cleared by it.
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pend_ff  <= srnvg_pkg::PEND_RST;
			stat_ff  <= srnvg_pkg::STAT_RST;
			mask_ff  <= srnvg_pkg::MASK_RST;
			rdata_ff <= 32'h00000000;
			err_ff   <= 1'b0;
			ridx_ff  <= 5'h00;
			rvld_ff  <= 1'b0;
		end else begin
			pend_ff  <= nxt_pend;
			stat_ff  <= nxt_stat;
			mask_ff  <= nxt_mask;
			rdata_ff <= nxt_rdata;
			err_ff   <= nxt_err;
			ridx_ff  <= nxt_ridx;
			rvld_ff  <= nxt_rvld;
		end
	end

	assign apb_out.pready  = 1'b1;
	assign apb_out.pslverr = err_ff;
	assign apb_out.prdata  = rdata_ff;
	assign irq_out         = |(stat_ff & mask_ff);

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!nrst_in);

	// Group views let each check name the lowest pending source of its own group.
	logic                       rd_setup;
	logic                       vec_sel;
	logic [srnvg_pkg::NSRC-1:0] rst_only;
	logic [srnvg_pkg::NSRC-1:0] sys_only;
	assign rd_setup = setup & ~apb_in.pwrite;
	assign vec_sel  = (sel == srnvg_pkg::SEL_USR) | (sel == srnvg_pkg::SEL_SYS) |
		(sel == srnvg_pkg::SEL_RST);
	assign rst_only = pend_ff & 22'h003FFF;
	assign sys_only = pend_ff & 22'h0FC000;

	// Reset cause group, brownout class: these outrank every other reset cause.
	// Checks key on the lowest pending bit, so a draining sequence reaches each one.
	bor_first_a: assert property (
		rd_setup && sel == srnvg_pkg::SEL_RST && rst_only[0]
		|=> apb_out.prdata == 32'h00000002)
		else $error("brownout not reported first");
	pin_code_a: assert property (
		rd_setup && sel == srnvg_pkg::SEL_RST && (rst_only & 22'h000003) == 22'h000002
		|=> apb_out.prdata == 32'h00000004)
		else $error("reset pin code wrong");
	sw_bor_code_a: assert property (
		rd_setup && sel == srnvg_pkg::SEL_RST && (rst_only & 22'h000007) == 22'h000004
		|=> apb_out.prdata == 32'h00000006)
		else $error("software brownout code wrong");
	wake_code_a: assert property (
		rd_setup && sel == srnvg_pkg::SEL_RST && (rst_only & 22'h00000F) == 22'h000008
		|=> apb_out.prdata == 32'h00000008)
		else $error("deep wake code wrong");
	secure_code_a: assert property (
		rd_setup && sel == srnvg_pkg::SEL_RST && (rst_only & 22'h00001F) == 22'h000010
		|=> apb_out.prdata == 32'h0000000A)
		else $error("security code wrong");
	supv_code_a: assert property (
		rd_setup && sel == srnvg_pkg::SEL_RST && (rst_only & 22'h00003F) == 22'h000020
		|=> apb_out.prdata == 32'h0000000E)
		else $error("high supervisor code wrong");

	// Reset cause group, power-on and power-up-clear classes.
	swpor_code_a: assert property (
		rd_setup && sel == srnvg_pkg::SEL_RST && (rst_only & 22'h00007F) == 22'h000040
		|=> apb_out.prdata == 32'h00000014)
		else $error("software power-on code wrong");
	wdt_code_a: assert property (
		rd_setup && sel == srnvg_pkg::SEL_RST && (rst_only & 22'h0000FF) == 22'h000080
		|=> apb_out.prdata == 32'h00000016)
		else $error("watchdog code wrong");
	wdt_key_a: assert property (
		rd_setup && sel == srnvg_pkg::SEL_RST && (rst_only & 22'h0001FF) == 22'h000100
		|=> apb_out.prdata == 32'h00000018)
		else $error("watchdog key code wrong");
	nvm_key_a: assert property (
		rd_setup && sel == srnvg_pkg::SEL_RST && (rst_only & 22'h0003FF) == 22'h000200
		|=> apb_out.prdata == 32'h0000001A)
		else $error("memory controller key code wrong");
	nvm_fatal_a: assert property (
		rd_setup && sel == srnvg_pkg::SEL_RST && (rst_only & 22'h0007FF) == 22'h000400
		|=> apb_out.prdata == 32'h0000001C)
		else $error("uncorrectable memory reset code wrong");
	fetch_code_a: assert property (
		rd_setup && sel == srnvg_pkg::SEL_RST && (rst_only & 22'h000FFF) == 22'h000800
		|=> apb_out.prdata == 32'h0000001E)
		else $error("peripheral fetch code wrong");
	pmm_key_a: assert property (
		rd_setup && sel == srnvg_pkg::SEL_RST && (rst_only & 22'h001FFF) == 22'h001000
		|=> apb_out.prdata == 32'h00000020)
		else $error("power key code wrong");
	fll_code_a: assert property (
		rd_setup && sel == srnvg_pkg::SEL_RST && (rst_only & 22'h003FFF) == 22'h002000
		|=> apb_out.prdata == 32'h00000024)
		else $error("lock loss code wrong");

	// System group.
	svs_first_a: assert property (
		rd_setup && sel == srnvg_pkg::SEL_SYS && sys_only[14]
		|=> apb_out.prdata == 32'h00000002)
		else $error("supervisor entry not first");
	sys_fatal_a: assert property (
		rd_setup && sel == srnvg_pkg::SEL_SYS && (sys_only & 22'h00C000) == 22'h008000
		|=> apb_out.prdata == 32'h00000004)
		else $error("uncorrectable memory code wrong");
	vacant_code_a: assert property (
		rd_setup && sel == srnvg_pkg::SEL_SYS && (sys_only & 22'h01C000) == 22'h010000
		|=> apb_out.prdata == 32'h00000012)
		else $error("vacant access code wrong");
	mbox_in_a: assert property (
		rd_setup && sel == srnvg_pkg::SEL_SYS && (sys_only & 22'h03C000) == 22'h020000
		|=> apb_out.prdata == 32'h00000014)
		else $error("mailbox input code wrong");
	mbox_out_a: assert property (
		rd_setup && sel == srnvg_pkg::SEL_SYS && (sys_only & 22'h07C000) == 22'h040000
		|=> apb_out.prdata == 32'h00000016)
		else $error("mailbox output code wrong");
	nvm_fix_a: assert property (
		rd_setup && sel == srnvg_pkg::SEL_SYS && (sys_only & 22'h0FC000) == 22'h080000
		|=> apb_out.prdata == 32'h00000018)
		else $error("correctable memory code wrong");

	// User group.
	usr_prio_a: assert property (
		rd_setup && sel == srnvg_pkg::SEL_USR && pend_ff[21:20] == 2'h3
		|=> apb_out.prdata == 32'h00000002)
		else $error("user vector priority wrong");
	usr_osc_a: assert property (
		rd_setup && sel == srnvg_pkg::SEL_USR && pend_ff[21:20] == 2'h2
		|=> apb_out.prdata == 32'h00000004)
		else $error("oscillator fault code wrong");

	// Idle groups and the unused upper bits of a vector word.
	idle_zero_a: assert property (
		rd_setup && sel == srnvg_pkg::SEL_USR && pend_ff[21:20] == 2'h0
		|=> apb_out.prdata == 32'h00000000)
		else $error("idle vector not zero");
	sys_idle_a: assert property (
		rd_setup && sel == srnvg_pkg::SEL_SYS && sys_only == 22'h000000
		|=> apb_out.prdata == 32'h00000000)
		else $error("idle system vector not zero");
	rst_idle_a: assert property (
		rd_setup && sel == srnvg_pkg::SEL_RST && rst_only == 22'h000000
		|=> apb_out.prdata == 32'h00000000)
		else $error("idle reset vector not zero");
	upper_zero_a: assert property (
		rd_setup && vec_sel
		|=> apb_out.prdata[31:8] == 24'h000000)
		else $error("vector upper bits not zero");

	// Pending flags and the read clear.
	read_clears_a: assert property (
		rclr && !ev[ridx_ff]
		|=> !pend_ff[$past(ridx_ff)])
		else $error("read did not clear source");
	sticky_hold_a: assert property (
		##1 ((($past(pend_ff) & ~$past(clr_vec))
		| $past(ev)) & ~pend_ff) == 22'h000000)
		else $error("pending flag lost");
	write_keeps_a: assert property (
		acc && apb_in.pwrite && ev == 22'h000000
		|=> pend_ff == $past(pend_ff))
		else $error("write changed pending flags");

	// Status, mask and interrupt; an event wins over a clear in the same cycle.
	sys_stat_a: assert property (
		ev[srnvg_pkg::SYS_HI:srnvg_pkg::SYS_LO] != 6'h00
		|=> stat_ff[srnvg_pkg::ST_SYS])
		else $error("system status not set");
	usr_stat_a: assert property (
		ev[srnvg_pkg::USR_HI:srnvg_pkg::USR_LO] != 2'h0
		|=> stat_ff[srnvg_pkg::ST_USR])
		else $error("user status not set");
	rst_stat_a: assert property (
		ev[srnvg_pkg::RST_HI:srnvg_pkg::RST_LO] != 14'h0000
		|=> stat_ff[srnvg_pkg::ST_RST])
		else $error("reset status not set");
	mask_write_a: assert property (
		acc && apb_in.pwrite && sel == srnvg_pkg::SEL_MASK
		|=> mask_ff == $past(apb_in.pwdata[srnvg_pkg::NST-1:0]))
		else $error("mask write lost");
	irq_clear_a: assert property (
		acc && apb_in.pwrite && sel == srnvg_pkg::SEL_STAT && apb_in.pwdata[2:0] == 3'h7 &&
		set_stat == 3'h0 |=> !irq_out)
		else $error("interrupt not cleared");

	// Register bus answers.
	unmapped_err_a: assert property (
		setup && sel == srnvg_pkg::SEL_NONE
		|=> apb_out.pslverr && apb_out.prdata == 32'h00000000)
		else $error("unmapped address not refused");
	mapped_ok_a: assert property (
		setup && sel != srnvg_pkg::SEL_NONE
		|=> !apb_out.pslverr)
		else $error("mapped address refused");
	rdata_stands_a: assert property (
		!setup
		|=> $stable(apb_out.prdata) && $stable(apb_out.pslverr))
		else $error("read data moved outside setup");

	// Main scenarios worth seeing.
	rd_rst_c: cover property (rclr && ridx_ff <= 5'(srnvg_pkg::RST_HI));
	rd_sys_c: cover property (rclr && ridx_ff >= 5'(srnvg_pkg::SYS_LO));
	rd_usr_c: cover property (rclr && ridx_ff >= 5'(srnvg_pkg::USR_LO));
	clash_c:  cover property (rclr && ev[ridx_ff]);
	irq_c:    cover property ($rose(irq_out));
endmodule

// >>> common/srnvg_pkg.sv
// Constants, types and the register map of the reset and non-maskable vector generator.
package srnvg_pkg;
	localparam int NSRC   = 22;
	localparam int RST_LO = 0;
	localparam int RST_HI = 13;
	localparam int SYS_LO = 14;
	localparam int SYS_HI = 19;
	localparam int USR_LO = 20;
	localparam int USR_HI = 21;

	// Source bit order inside each group follows the vector code, smallest first.
	localparam logic [7:0] CODE [NSRC] = '{
		8'h02, 8'h04, 8'h06, 8'h08, 8'h0A, 8'h0E, 8'h14,
		8'h16, 8'h18, 8'h1A, 8'h1C, 8'h1E, 8'h20, 8'h24,
		8'h02, 8'h04, 8'h12, 8'h14, 8'h16, 8'h18,
		8'h02, 8'h04
	};
	localparam logic [7:0] CODE_NONE = 8'h00;

	localparam logic [11:0] USR_IDX   = 12'h15A;
	localparam logic [11:0] SYS_IDX   = 12'h15C;
	localparam logic [11:0] RST_IDX   = 12'h15E;
	localparam logic [11:0] USR_ADDR  = {USR_IDX[9:0], 2'h0};
	localparam logic [11:0] SYS_ADDR  = {SYS_IDX[9:0], 2'h0};
	localparam logic [11:0] RST_ADDR  = {RST_IDX[9:0], 2'h0};
	localparam logic [11:0] STAT_ADDR = 12'h580;
	localparam logic [11:0] MASK_ADDR = 12'h584;

	localparam int NST    = 3;
	localparam int ST_SYS = 0;
	localparam int ST_USR = 1;
	localparam int ST_RST = 2;
	localparam logic [NST-1:0]  STAT_RST = 3'h4;
	localparam logic [NST-1:0]  MASK_RST = 3'h0;
	localparam logic [NSRC-1:0] PEND_RST = 22'h000001;

	typedef logic [4:0] srnvg_idx_t;

	typedef enum logic [5:0] {
		SEL_NONE = 6'b000001,
		SEL_USR  = 6'b000010,
		SEL_SYS  = 6'b000100,
		SEL_RST  = 6'b001000,
		SEL_STAT = 6'b010000,
		SEL_MASK = 6'b100000
	} srnvg_sel_e;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} srnvg_apb_req_s;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} srnvg_apb_rsp_s;

	// Last field is bit 0; order matches CODE.
	typedef struct packed {
		logic usr_osc_fault;
		logic usr_pin_nmi;
		logic sys_nvm_correctable;
		logic sys_mailbox_out;
		logic sys_mailbox_in;
		logic sys_vacant_access;
		logic sys_nvm_uncorrectable;
		logic sys_supervisor_lp_entry;
		logic rst_fll_unlock;
		logic rst_power_mgmt_key;
		logic rst_periph_fetch;
		logic rst_nvm_uncorrectable;
		logic rst_nvm_controller_key;
		logic rst_watchdog_key;
		logic rst_watchdog_expiry;
		logic rst_sw_power_on;
		logic rst_high_supervisor;
		logic rst_security;
		logic rst_lpm_wakeup;
		logic rst_sw_brownout;
		logic rst_reset_pin;
		logic rst_brownout;
	} srnvg_evt_s;
endpackage

// >>> dv/system_reset_nmi_vector_generator_test.sv
// Self-checking testbench for the reset and non-maskable vector generator.
module system_reset_nmi_vector_generator_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic                      clk_in;
	logic                      nrst_in;
	srnvg_pkg::srnvg_apb_req_s req;
	srnvg_pkg::srnvg_apb_rsp_s rsp;
	srnvg_pkg::srnvg_evt_s     evt;
	logic                      irq;
	int                        fail_count = 0;
	int                        n_tests = 0;
	int                        cyc = 0;
	logic [31:0]               d;
	logic                      e;
	// Expected codes in source bit order, written out independently of the package.
	logic [7:0]                exp_code [22] = '{
		8'h02, 8'h04, 8'h06, 8'h08, 8'h0A, 8'h0E, 8'h14, 8'h16, 8'h18, 8'h1A, 8'h1C,
		8'h1E, 8'h20, 8'h24, 8'h02, 8'h04, 8'h12, 8'h14, 8'h16, 8'h18, 8'h02, 8'h04};

	srnvg_top dut (
		.clk_in  (clk_in),
		.nrst_in (nrst_in),
		.apb_in  (req),
		.evt_in  (evt),
		.apb_out (rsp),
		.irq_out (irq)
	);

	always #20 clk_in = ~clk_in;

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// A hang in a wait loop ends the run here with a mismatch counted.
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fail_count++;
			summarize();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Data and error are taken at the edge where pready is sampled high.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		req.psel    <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite  <= w;
		req.paddr   <= a;
		req.pwdata  <= wd;
		@(posedge clk_in);
		req.penable <= 1'b1;
		do @(posedge clk_in); while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel    <= 1'b0;
		req.penable <= 1'b0;
		@(posedge clk_in);
	endtask

	task automatic pulse(input logic [21:0] m);
		evt <= m;
		@(posedge clk_in);
		evt <= '0;
		@(posedge clk_in);
	endtask

	task automatic drain(input logic [11:0] a, input int lo, input int hi);
		for (int i = lo; i <= hi; i++) begin
			apb(1'b0, a, 32'h0, d, e);
			chk(d, {24'h0, exp_code[i]});
		end
		apb(1'b0, a, 32'h0, d, e);
		chk(d, 32'h0);
	endtask

	task automatic t_reset();
		chk({31'h0, irq}, 32'h0);
		apb(1'b0, srnvg_pkg::STAT_ADDR, 32'h0, d, e);
		chk(d, 32'h4);
		apb(1'b0, srnvg_pkg::MASK_ADDR, 32'h0, d, e);
		chk(d, 32'h0);
		drain(srnvg_pkg::RST_ADDR, 0, 0);
	endtask

	// All sources of a group pending at once must come out in priority order.
	task automatic t_groups();
		pulse(22'h003FFF);
		drain(srnvg_pkg::RST_ADDR, 0, 13);
		pulse(22'h003FFE);
		drain(srnvg_pkg::RST_ADDR, 1, 13);
		pulse(22'h0FC000);
		drain(srnvg_pkg::SYS_ADDR, 14, 19);
		pulse(22'h300000);
		drain(srnvg_pkg::USR_ADDR, 20, 21);
	endtask

	task automatic t_irq();
		apb(1'b1, srnvg_pkg::STAT_ADDR, 32'h7, d, e);
		apb(1'b1, srnvg_pkg::MASK_ADDR, 32'h2, d, e);
		pulse(22'h004000);
		chk({31'h0, irq}, 32'h0);
		pulse(22'h200000);
		chk({31'h0, irq}, 32'h1);
		apb(1'b0, srnvg_pkg::STAT_ADDR, 32'h0, d, e);
		chk(d, 32'h3);
		apb(1'b1, srnvg_pkg::STAT_ADDR, 32'h2, d, e);
		chk({31'h0, irq}, 32'h0);
		apb(1'b0, srnvg_pkg::STAT_ADDR, 32'h0, d, e);
		chk(d, 32'h1);
		drain(srnvg_pkg::SYS_ADDR, 14, 14);
		drain(srnvg_pkg::USR_ADDR, 21, 21);
	endtask

	// The event is high only at the clearing edge, so only a winning set keeps it.
	task automatic t_coincide();
		pulse(22'h010000);
		fork
			apb(1'b0, srnvg_pkg::SYS_ADDR, 32'h0, d, e);
			begin
				@(posedge clk_in);
				evt <= 22'h010000;
				@(posedge clk_in);
				evt <= '0;
			end
		join
		chk(d, 32'h12);
		drain(srnvg_pkg::SYS_ADDR, 16, 16);
	endtask

	task automatic t_refuse();
		apb(1'b0, 12'h590, 32'h0, d, e);
		chk({31'h0, e}, 32'h1);
		chk(d, 32'h0);
		apb(1'b1, 12'h588, 32'h5, d, e);
		chk({31'h0, e}, 32'h1);
		apb(1'b1, srnvg_pkg::RST_ADDR, 32'h1E, d, e);
		chk({31'h0, e}, 32'h0);
		apb(1'b0, srnvg_pkg::MASK_ADDR, 32'h0, d, e);
		chk(d, 32'h2);
		drain(srnvg_pkg::RST_ADDR, 0, -1);
	endtask

	initial begin
		clk_in = 1'b0;
		nrst_in = 1'b0;
		req = '0;
		evt = '0;
		repeat (6) @(posedge clk_in);
		nrst_in <= 1'b1;
		@(posedge clk_in);
		t_reset();
		t_groups();
		t_irq();
		t_coincide();
		t_refuse();
		summarize();
	end
endmodule
